// [rtl/fsro_pkg.sv]
/*
 Constants, register map and field layout for the fail-safe reset output control.
 Assumes one 125 MHz clock (hclk) and an AHB-Lite register port.
*/
`default_nettype none
package fsro_pkg;
    localparam logic [7:0] FSRO_CFG_ADDR = 8'h00;
    localparam logic [7:0] FSRO_STAT_ADDR = 8'h04;
    localparam logic [7:0] FSRO_CTRL_ADDR = 8'h08;
    localparam int FSRO_NMON = 3;
    localparam int FSRO_NFLT = 6;
    // cfg register fields
    localparam int FSRO_LIM_LSB = 0;
    localparam int FSRO_LINK_BIT = 2;
    localparam int FSRO_ASGN_LSB = 3;
    localparam int FSRO_IMP_LSB = 6;
    localparam int FSRO_IMP_W = 12;
    localparam logic [1:0] FSRO_LIM_RST = 2'h1;
    localparam logic [2:0] FSRO_ASGN_RST = 3'h7;
    // per fault impact, uv0 uv1 uv2 ov0 ov1 ov2, two bits each; upper bit asserts reset
    localparam logic [11:0] FSRO_IMP_RST = 12'hA95;
    // status register fields, then the ctrl done bit, counter start, limit values and htrans codes
    localparam int FSRO_CNT_LSB = 8;
    localparam int FSRO_DEEP_BIT = 12;
    localparam int FSRO_INIT_BIT = 13;
    localparam int FSRO_LINE_BIT = 14;
    localparam int FSRO_SG_BIT = 15;
    localparam int FSRO_RST_BIT = 16;
    localparam int FSRO_DONE_BIT = 0;
    localparam logic [3:0] FSRO_CNT_START = 4'h1;
    localparam logic [3:0] FSRO_LIM_2 = 4'h2;
    localparam logic [3:0] FSRO_LIM_6 = 4'h6;
    localparam logic [3:0] FSRO_LIM_8 = 4'h8;
    localparam logic [3:0] FSRO_LIM_12 = 4'hC;
    localparam logic [1:0] FSRO_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] FSRO_HTRANS_SEQ = 2'h3;
endpackage : fsro_pkg
`default_nettype wire

// [rtl/fsro_top.sv]
/*
 Fail-safe supply-good and reset output control with AHB-Lite configuration slave.
 Assumes monitor flags and the sensed reset line arrive asynchronously; mode and
 logic-failure inputs come from logic on hclk. Pads resolve open drain from oe_n.
*/
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module fsro_top
    import fsro_pkg::*;
#(
    parameter int unsigned STUCK_CYCLES = 32'd1000000
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // rail monitors: 0 core, 1 io, 2 aux
    input wire logic [2:0] mon_uv,
    input wire logic [2:0] mon_ov,
    // device state
    input wire logic standby_mode,
    input wire logic power_down_mode,
    input wire logic safety_logic_fail,
    // open-drain pins, then the deep safe state output
    input wire logic mcu_reset_sense,
    output logic supply_ok_n_o,
    output logic supply_ok_n_oe_n,
    output logic mcu_reset_out_n_o,
    output logic mcu_reset_out_n_oe_n,
    output logic deep_safe_state
);
    localparam int NS = 7;

    logic [NS-1:0] sync1_ff, sync2_ff, sync3_ff, stable_ff;
    logic [1:0] lim_ff;
    logic link_ff;
    logic [2:0] asgn_ff;
    logic [FSRO_IMP_W-1:0] imp_ff;
    logic init_ff;
    logic [FSRO_NFLT-1:0] flag_ff;
    logic [3:0] cnt_ff;
    logic rfault_q_ff;
    logic deep_ff;
    logic [31:0] stuck_ff;
    logic sg_drive_ff, rst_drive_ff;
    logic sg_oe_n_ff, rst_oe_n_ff;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [31:0] rdata_ff;

    logic [FSRO_NFLT-1:0] flt;
    logic [FSRO_NFLT-1:0] flt_rst;
    logic [2:0] mon_bad;
    logic line_high, rfault, sg_mon, cnt_inc, force_low;
    logic nxt_sg_drive, nxt_rst_drive;
    logic [3:0] lim_val;
    logic addr_ok;
    logic [31:0] stat_word, cfg_word;

    // three-stage sync; value accepted once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            stable_ff <= '0;
        end else begin
            sync1_ff <= {mcu_reset_sense, mon_ov, mon_uv};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            for (int i = 0; i < NS; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    stable_ff[i] <= sync3_ff[i];
                end
            end
        end
    end

    assign flt = stable_ff[FSRO_NFLT-1:0];
    assign line_high = stable_ff[NS-1];
    assign mon_bad = flt[2:0] | flt[5:3];

    always_comb begin
        for (int k = 0; k < FSRO_NFLT; k++) begin
            flt_rst[k] = flt[k] & imp_ff[2*k+1];
        end
    end
    assign rfault = |flt_rst;

    always_comb begin
        case (lim_ff)
            2'h0: lim_val = FSRO_LIM_2;
            2'h1: lim_val = FSRO_LIM_6;
            2'h2: lim_val = FSRO_LIM_8;
            default: lim_val = FSRO_LIM_12;
        endcase
    end

    // pin decision: supply-good first, reset follows it
    assign sg_mon = |(mon_bad & asgn_ff);
    assign force_low = standby_mode | power_down_mode | safety_logic_fail | deep_ff;
    assign nxt_sg_drive = force_low | sg_mon | (link_ff & rfault);
    assign nxt_rst_drive = nxt_sg_drive | rfault;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sg_drive_ff <= 1'b1;
            rst_drive_ff <= 1'b1;
        end else begin
            sg_drive_ff <= nxt_sg_drive;
            rst_drive_ff <= nxt_rst_drive;
        end
    end

    // open drain: data is always low, only the enable moves
    assign supply_ok_n_o = 1'b0;
    assign mcu_reset_out_n_o = 1'b0;
    assign supply_ok_n_oe_n = sg_oe_n_ff;
    assign mcu_reset_out_n_oe_n = rst_oe_n_ff;
    assign deep_safe_state = deep_ff;

    // pad enables get their own flops: no gate between register and pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sg_oe_n_ff <= 1'b0;
            rst_oe_n_ff <= 1'b0;
        end else begin
            sg_oe_n_ff <= ~nxt_sg_drive;
            rst_oe_n_ff <= ~nxt_rst_drive;
        end
    end

    // count new reset-asserting faults only while reset is released
    assign cnt_inc = rfault & ~rfault_q_ff & ~rst_drive_ff & ~deep_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= FSRO_CNT_START;
            rfault_q_ff <= 1'b0;
        end else begin
            rfault_q_ff <= rfault;
            if (standby_mode) begin
                cnt_ff <= FSRO_CNT_START;
            end else if (cnt_inc && cnt_ff < lim_val) begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end

    // stuck-low watchdog on the sensed reset line
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stuck_ff <= '0;
        end else if (line_high) begin
            stuck_ff <= '0;
        end else if (stuck_ff < STUCK_CYCLES) begin
            stuck_ff <= stuck_ff + 32'h1;
        end
    end

    // deep safe is only left through power-on reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            deep_ff <= 1'b0;
        end else if (stuck_ff >= STUCK_CYCLES || cnt_ff >= lim_val) begin
            deep_ff <= 1'b1;
        end
    end

    // ahb-lite: zero wait states, writes land in the data phase
    assign addr_ok = hsel && hready && (htrans == FSRO_HTRANS_NONSEQ || htrans == FSRO_HTRANS_SEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_ff <= addr_ok && hwrite;
            wr_addr_ff <= haddr;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    assign cfg_word = {14'h0, imp_ff, asgn_ff, link_ff, lim_ff};
    assign stat_word = {15'h0, rst_drive_ff, sg_drive_ff, line_high, init_ff, deep_ff,
                        cnt_ff, 2'h0, flag_ff};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= '0;
        end else if (addr_ok && !hwrite) begin
            case (haddr)
                FSRO_CFG_ADDR: rdata_ff <= cfg_word;
                FSRO_STAT_ADDR: rdata_ff <= stat_word;
                FSRO_CTRL_ADDR: rdata_ff <= {31'h0, ~init_ff};
                default: rdata_ff <= '0;
            endcase
        end
    end
    assign hrdata = rdata_ff;

    // configuration only accepted during the init phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lim_ff <= FSRO_LIM_RST;
            link_ff <= 1'b0;
            asgn_ff <= FSRO_ASGN_RST;
            imp_ff <= FSRO_IMP_RST;
        end else if (wr_pend_ff && init_ff && wr_addr_ff == FSRO_CFG_ADDR) begin
            lim_ff <= hwdata[FSRO_LIM_LSB +: 2];
            link_ff <= hwdata[FSRO_LINK_BIT];
            asgn_ff <= hwdata[FSRO_ASGN_LSB +: 3];
            imp_ff <= hwdata[FSRO_IMP_LSB +: FSRO_IMP_W];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_ff <= 1'b1;
        end else if (wr_pend_ff && wr_addr_ff == FSRO_CTRL_ADDR && hwdata[FSRO_DONE_BIT]) begin
            init_ff <= 1'b0;
        end
    end

    // sticky diagnostic flags, write one to clear, a new fault wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_ff <= '0;
        end else if (wr_pend_ff && wr_addr_ff == FSRO_STAT_ADDR) begin
            flag_ff <= (flag_ff & ~hwdata[FSRO_NFLT-1:0]) | flt;
        end else begin
            flag_ff <= flag_ff | flt;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_new_fault;
        rfault && !rfault_q_ff && !rst_drive_ff && !deep_ff && !standby_mode;
    endsequence
    sequence s_below_limit;
        cnt_ff < lim_val;
    endsequence
    sequence s_cfg_held;
        $stable({lim_ff, link_ff, asgn_ff, imp_ff});
    endsequence

    chk_sg_forces_rst: assert property (sg_drive_ff |-> rst_drive_ff)
        else $error("supply-good low without reset low");
    chk_sg_open_drain: assert property (supply_ok_n_o == 1'b0)
        else $error("supply-good drives high");
    chk_rst_open_drain: assert property (mcu_reset_out_n_o == 1'b0)
        else $error("reset output drives high");
    chk_standby_sg_low: assert property (standby_mode || power_down_mode |=> !supply_ok_n_oe_n)
        else $error("supply-good released in low-power mode");
    chk_standby_rst_low: assert property (standby_mode || power_down_mode |=> !mcu_reset_out_n_oe_n)
        else $error("reset released in low-power mode");
    chk_fail_both_low: assert property (safety_logic_fail |=> sg_drive_ff && rst_drive_ff)
        else $error("outputs released on logic failure");
    chk_count_step: assert property (s_new_fault and s_below_limit |=> cnt_ff == $past(cnt_ff) + 4'h1)
        else $error("fault counter did not step by one");
    chk_count_quiet: assert property (!rfault && !standby_mode |=> $stable(cnt_ff))
        else $error("fault counter moved without a reset fault");
    chk_limit_deep: assert property (cnt_ff >= lim_val |=> deep_ff ##1 sg_drive_ff && rst_drive_ff)
        else $error("limit reached without deep safe state");
    chk_deep_sticky: assert property (deep_ff |=> deep_ff)
        else $error("deep safe state left");
    chk_stuck_deep: assert property (stuck_ff >= STUCK_CYCLES |=> deep_ff)
        else $error("stuck reset line ignored");
    chk_stuck_restart: assert property (line_high |=> stuck_ff == 32'h0)
        else $error("stuck counter not restarted");
    chk_link_sg: assert property (link_ff && rfault |=> sg_drive_ff)
        else $error("linked fault did not assert supply-good");
    chk_monitor_sg: assert property (|(mon_bad & asgn_ff) |=> sg_drive_ff)
        else $error("assigned monitor fault did not assert supply-good");
    chk_cfg_locked: assert property (!init_ff |=> s_cfg_held)
        else $error("configuration changed after init phase");
    chk_flag_set: assert property (flt != '0 |=> (flag_ff & $past(flt)) == $past(flt))
        else $error("fault flag not set");
    chk_start_one: assert property (standby_mode |=> cnt_ff == FSRO_CNT_START)
        else $error("fault counter not back at start after standby");
    chk_deep_pins: assert property (deep_ff |=> !supply_ok_n_oe_n && !mcu_reset_out_n_oe_n)
        else $error("pins released in deep safe state");
    chk_rst_follows: assert property (rfault |=> rst_drive_ff)
        else $error("reset-impact fault did not assert reset");
endmodule : fsro_top
`default_nettype wire

// [bench/fsro_mcu_model.sv]
/*
 Controller side of the supply-good and reset lines: pull-ups on both,
 and the controller's own ability to hold its reset line low.
 Assumes oe_n low means the device pulls the pin to its _o level.
*/
`timescale 1ns/1ns
`default_nettype none
module fsro_mcu_model (
    // pads from the device
    input wire logic supply_ok_n_o,
    input wire logic supply_ok_n_oe_n,
    input wire logic mcu_reset_out_n_o,
    input wire logic mcu_reset_out_n_oe_n,
    // controller side
    input wire logic hold_reset_low,
    output logic supply_ok_line,
    output logic reset_line
);
    // released pins float up to the external pull-up
    assign supply_ok_line = supply_ok_n_oe_n ? 1'b1 : supply_ok_n_o;
    // wired-and: either party may pull reset low
    assign reset_line = (mcu_reset_out_n_oe_n ? 1'b1 : mcu_reset_out_n_o) & ~hold_reset_low;
endmodule : fsro_mcu_model
`default_nettype wire

// [bench/fsro_top_tb.sv]
/*
 Self-checking bench for the fail-safe output control.
 Assumes fsro_top with a shortened stuck timeout and the controller model.
*/
`timescale 1ns/1ns
`default_nettype none
module fsro_top_tb
    import fsro_pkg::*;
;
    typedef struct {logic [2:0] uv; logic [2:0] ov; logic sb, pd, fl, sg, rs;} fsro_row_t;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hold = 0, sb = 0, pd = 0, fl = 0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, rd;
    logic [2:0] uv = 3'h0, ov = 3'h0;
    wire logic hready, hresp, sg_o, sg_oe, rs_o, rs_oe, deep, sg_line, rs_line;
    wire logic [31:0] hrdata;
    int bad_count = 0, compares = 0;
    fsro_row_t rows[9] = '{'{0, 0, 0, 0, 0, 1, 1}, '{1, 0, 0, 0, 0, 0, 0},
        '{2, 0, 0, 0, 0, 0, 0}, '{4, 0, 0, 0, 0, 0, 0}, '{0, 1, 0, 0, 0, 0, 0},
        '{0, 4, 0, 0, 0, 0, 0}, '{0, 0, 1, 0, 0, 0, 0}, '{0, 0, 0, 1, 0, 0, 0},
        '{0, 0, 0, 0, 1, 0, 0}};
    always #4 hclk = ~hclk;
    fsro_top #(.STUCK_CYCLES(50)) fsro_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .mon_uv(uv),
        .mon_ov(ov), .standby_mode(sb), .power_down_mode(pd), .safety_logic_fail(fl),
        .mcu_reset_sense(rs_line), .supply_ok_n_o(sg_o), .supply_ok_n_oe_n(sg_oe),
        .mcu_reset_out_n_o(rs_o), .mcu_reset_out_n_oe_n(rs_oe), .deep_safe_state(deep));
    fsro_mcu_model fsro_mcu_model_i (.supply_ok_n_o(sg_o), .supply_ok_n_oe_n(sg_oe),
        .mcu_reset_out_n_o(rs_o), .mcu_reset_out_n_oe_n(rs_oe), .hold_reset_low(hold),
        .supply_ok_line(sg_line), .reset_line(rs_line));
    task conclude;
        if (bad_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    task chk_line(input string n, input logic e, input logic s);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %b seen %b", n, e, s);
        end
    endtask : chk_line
    task chk_word(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask : chk_word
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; htrans <= FSRO_HTRANS_NONSEQ; hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task apply(input logic [2:0] u, input logic [2:0] o, input logic s, p, f);
        @(posedge hclk);
        uv <= u; ov <= o; sb <= s; pd <= p; fl <= f;
    endtask : apply
    // monitor path needs about five edges, eight leaves margin
    task look(input logic sg, input logic rs);
        repeat (8) @(posedge hclk);
        #2;
        chk_line("supply_ok_line", sg, sg_line);
        chk_line("reset_line", rs, rs_line);
    endtask : look
    task rst;
        @(posedge hclk);
        hresetn <= 1'b0;
        apply(0, 0, 0, 0, 0);
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : rst
    task hold_for(input int n);
        @(posedge hclk);
        hold <= 1'b1;
        repeat (n) @(posedge hclk);
        hold <= 1'b0;
        repeat (10) @(posedge hclk);
        #2;
    endtask : hold_for
    initial begin
        #200000;
        bad_count++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, FSRO_CFG_ADDR, 0);
        chk_word("cfg", 32'h0002A579, rd);
        chk_line("hresp", 1'b0, hresp);
        bus(0, FSRO_STAT_ADDR, 0);
        chk_word("count", 32'h1, (rd >> 8) & 32'h1F);
        bus(0, 8'hFC, 0);
        chk_word("unmapped", 32'h0, rd);
        foreach (rows[i]) begin
            apply(rows[i].uv, rows[i].ov, rows[i].sb, rows[i].pd, rows[i].fl);
            look(rows[i].sg, rows[i].rs);
            apply(0, 0, 0, 0, 0);
            look(1, 1);
        end
        bus(0, FSRO_STAT_ADDR, 0);
        chk_word("count", 32'h1, (rd >> 8) & 32'h1F);
        chk_word("stat", 32'h0000612F, rd);
        bus(1, FSRO_STAT_ADDR, 32'h3F);
        bus(0, FSRO_STAT_ADDR, 0);
        chk_word("flags", 32'h0, rd & 32'h3F);
        // limit 12 so the counted faults below stay short of deep safe
        bus(1, FSRO_CFG_ADDR, 32'h0002A573);
        apply(1, 0, 0, 0, 0);
        look(1, 1);
        apply(0, 1, 0, 0, 0);
        look(1, 0);
        apply(0, 0, 0, 0, 0);
        bus(1, FSRO_CFG_ADDR, 32'h0002A577);
        apply(0, 1, 0, 0, 0);
        look(0, 0);
        apply(0, 0, 0, 0, 0);
        bus(1, FSRO_CFG_ADDR, 32'h0002A5B3);
        apply(1, 0, 0, 0, 0);
        look(1, 0);
        apply(0, 0, 0, 0, 0);
        bus(0, FSRO_STAT_ADDR, 0);
        chk_word("count", 32'h4, (rd >> 8) & 32'h1F);
        bus(1, FSRO_CTRL_ADDR, 32'h1);
        bus(0, FSRO_CTRL_ADDR, 0);
        chk_word("ctrl", 32'h1, rd);
        bus(1, FSRO_CFG_ADDR, 32'h0);
        bus(0, FSRO_CFG_ADDR, 0);
        chk_word("cfg", 32'h0002A5B3, rd);
        rst();
        bus(1, FSRO_CFG_ADDR, 32'h0002A578);
        apply(0, 1, 0, 0, 0);
        look(0, 0);
        apply(0, 0, 0, 0, 0);
        look(0, 0);
        chk_line("deep", 1'b1, deep);
        bus(0, FSRO_STAT_ADDR, 0);
        chk_word("stat", 32'h0001B208, rd);
        // limit code 2 (limit 8): six counted faults stay clear, the seventh goes deep
        rst();
        bus(1, FSRO_CFG_ADDR, 32'h0002A57A);
        repeat (6) begin
            apply(0, 1, 0, 0, 0);
            look(0, 0);
            apply(0, 0, 0, 0, 0);
            look(1, 1);
        end
        chk_line("deep", 1'b0, deep);
        apply(0, 1, 0, 0, 0);
        look(0, 0);
        chk_line("deep", 1'b1, deep);
        rst();
        repeat (10) @(posedge hclk);
        hold_for(40);
        chk_line("deep", 1'b0, deep);
        hold_for(40);
        chk_line("deep", 1'b0, deep);
        hold_for(70);
        chk_line("deep", 1'b1, deep);
        conclude();
    end
endmodule : fsro_top_tb
`default_nettype wire
